// ==== ihp_consts.svh ====
`ifndef IHP_CONSTS_SVH
`define IHP_CONSTS_SVH
// device register indices, on address bits 2:0
`define IHP_OFS_CONFIG_REG_SIXTEEN 3'h0
`define IHP_OFS_CONFIG_REG_THIRTY_ONE 3'h1
`define IHP_OFS_CONFIG_REG_3A 3'h2
`define IHP_OFS_CONFIG_REG_2C 3'h3
`define IHP_OFS_MODE 3'h4
`define IHP_OFS_ROUTE 3'h5
`define IHP_OFS_GPIO 3'h6
`define IHP_OFS_LAST 3'h6
// device register fields
`define IHP_BIT_PINA_SEL 5
`define IHP_BIT_PINB_SEL 4
`define IHP_BIT_SERIAL_IRQ_LINE 4
`define IHP_BIT_MGMT_IRQ_ENABLE 0
`define IHP_BIT_CLKSEL 0
`define IHP_MODE_ECP 0
`define IHP_MODE_EPP 1
`define IHP_MODE_ACPI 2
`define IHP_RST_BYTE 8'h00
// pin positions in the interrupt pin vector
`define IHP_PIN_A 0
`define IHP_PIN_B 1
`define IHP_PIN_G 6
`define IHP_PIN_H 7
// pulse timing
`define IHP_PULSE_NS 200
`define IHP_CLK_MHZ 250
`define IHP_PULSE_CYC ((`IHP_PULSE_NS * `IHP_CLK_MHZ + 999) / 1000)
// host apb map
`define IHP_APB_CMD 8'h00
`define IHP_APB_STATUS 8'h04
`define IHP_APB_CTRL 8'h08
`define IHP_APB_ISTAT 8'h0c
`define IHP_APB_IMASK 8'h10
`define IHP_CMD_A10 10
`define IHP_CMD_DLSB 11
`define IHP_CMD_WR 19
`define IHP_CTRL_MR 0
`define IHP_CTRL_DACK 1
`define IHP_CTRL_SER 2
`define IHP_CTRL_TC 3
`define IHP_EV_DONE 0
`define IHP_EV_DRQ 1
`define IHP_EV_SCI 2
`define IHP_EV_SMI 3
`define IHP_EV_SER 4
`endif

// ==== ihp_pkg.sv ====
`default_nettype none
package ihp_pkg;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SETUP = 2'b01,
    H_STROBE = 2'b10,
    H_RECOVER = 2'b11
  } ihp_hstate_t;

  typedef struct packed {
    logic [7:0] config_reg_sixteen;
    logic [7:0] config_reg_thirty_one;
    logic [7:0] config_reg_3a;
    logic [7:0] config_reg_2c;
    logic [7:0] mode;
    logic [2:0] route;
    logic [1:0] gpioOut;
    logic [1:0] gpioDir;
    logic [7:0] rdData;
    logic rdOe;
    logic iorPrev;
    logic iowPrev;
    logic [7:0] waitCnt;
    logic [2:0] drq;
    logic [2:0] dmaDone;
    logic [7:0] irqOut;
    logic [7:0] irqPrev;
    logic pciPrev;
    logic serPend;
    logic serLow;
  } ihp_dev_t;

  typedef struct packed {
    ihp_hstate_t state;
    logic [9:0] addr;
    logic a10;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] cnt;
    logic [2:0] ctrl;
    logic tc;
    logic [4:0] stat;
    logic [4:0] mask;
    logic [31:0] prdata;
    logic [7:0] pciCnt;
    logic pci_clock_in;
    logic sciPrev;
    logic smiPrev;
    logic serPrev;
    logic [2:0] drqPrev;
  } ihp_host_t;
endpackage
`default_nettype wire

// ==== ihp_isa_if.sv ====
`default_nettype none
interface ihp_isa_if;
  logic masterReset;
  logic csN;
  logic aen;
  logic iorN;
  logic iowN;
  logic [9:0] addr;
  logic addr10;
  logic tc;
  logic [2:0] dackN;
  logic [2:0] drq;
  logic [7:0] hostData;
  logic hostDataOe;
  logic [7:0] devData;
  logic devDataOe;
  logic chrdyOe;
  logic [7:0] pinOut;
  logic [7:0] pinOe;
  logic [1:0] pinExt;
  logic hostPciClk;
  logic hostPciOe;
  logic sciOe;
  logic smiOe;
  wire [7:0] dataBus;
  wire chrdy;
  wire [7:0] pinLevel;
  wire sciLevel;
  wire smiLevel;
  // wire resolution: drivers by enable, open drains pulled high
  assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : 8'hff);
  assign chrdy = !chrdyOe;
  assign sciLevel = !sciOe;
  assign smiLevel = !smiOe;
  assign pinLevel = (pinOe & pinOut) |
    (~pinOe & {1'b1, (hostPciOe ? hostPciClk : 1'b1), 4'hf, pinExt});

  modport dev (
    input masterReset, csN, aen, iorN, iowN, addr, addr10, tc, dackN, dataBus, pinLevel,
    output devData, devDataOe, chrdyOe, drq, pinOut, pinOe, sciOe, smiOe
  );
  modport host (
    output masterReset, csN, aen, iorN, iowN, addr, addr10, tc, dackN, hostData,
    output hostDataOe, hostPciClk, hostPciOe,
    input dataBus, chrdy, drq, pinLevel, sciLevel, smiLevel
  );
endinterface
`default_nettype wire

// ==== ihp_pulse.sv ====
`include "ihp_consts.svh"
`default_nettype none
module ihp_pulse #(
  parameter logic [7:0] CYCLES = 8'(`IHP_PULSE_CYC)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic fire,
  output logic active
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;

  // reload on each event, count down to zero
  always_comb begin
    next_cnt = cnt;
    if (cnt != 8'h00) next_cnt = cnt - 8'h01;
    if (fire) next_cnt = CYCLES;
  end

  always_ff @(posedge clk) begin
    if (reset) cnt <= 8'h00;
    else cnt <= next_cnt;
  end

  assign active = (cnt != 8'h00);
endmodule // ihp_pulse
`default_nettype wire

// ==== ihp_device.sv ====
// Overview of operation
// RULE1 - master reset high resets the device
// RULE2 - respond only while chip select is low
// RULE3 - eight-bit bidirectional data bus to host
// RULE4 - host gives ten-bit address for decode
// RULE5 - ECP mode adds address line ten decode
// RULE6 - address enable qualifies the I/O decode
// RULE7 - EPP mode stretches cycles via channel ready
// RULE8 - three DMA request and acknowledge pairs
// RULE9 - terminal count ends the active transfer
// RULE10 - external interrupt routed to selectable output
// RULE11 - pin A irq or gpio one by bit5
// RULE12 - pin B irq or gpio zero by bit4
// RULE13 - serial mode turns pin G into clock
// RULE14 - serial mode bit makes pin H serial
// RULE15 - ACPI event gives 200ns low system-control pulse
// RULE16 - legacy event gives 200ns low management pulse
// RULE17 - management pulse only while its enable set
// RULE18 - software sets clock select to match input
//
// The placing of the registers and the APB interface to the registers were decided locally.
`include "ihp_consts.svh"
`default_nettype none
module ihp_device #(
  parameter logic [9:0] BASE = 10'h300,
  parameter logic [7:0] EPP_WAIT = 8'h08
) (
  input wire logic clk,
  input wire logic reset,
  ihp_isa_if.dev bus,
  input wire logic [7:0] irqSrc,
  input wire logic routedIrqInput,
  input wire logic [2:0] dmaStart,
  input wire logic pmEvent,
  output logic [2:0] dmaDone,
  output logic clockSelect,
  output logic ecpMode,
  output logic eppMode,
  output logic acpiMode
);
  ihp_pkg::ihp_dev_t s;
  ihp_pkg::ihp_dev_t next_s;
  logic rst;
  logic hit;
  logic serMode;
  logic strobeFall;
  logic iowRise;
  logic pciRise;
  logic sciFire;
  logic smiFire;
  logic sciActive;
  logic smiActive;

  //------------------------------------------------------------
  // reset and decode
  //------------------------------------------------------------
  assign rst = reset || bus.masterReset; // [RULE1]
  assign serMode = s.config_reg_thirty_one[`IHP_BIT_SERIAL_IRQ_LINE];
  // window of base plus register indices, a10 only in ecp mode
  assign hit = !bus.csN // [RULE2]
    && !bus.aen // [RULE6]
    && (bus.addr[9:3] == BASE[9:3]) && (bus.addr[2:0] <= `IHP_OFS_LAST) // [RULE4]
    && (!s.mode[`IHP_MODE_ECP] || !bus.addr10); // [RULE5]
  assign strobeFall = (s.iorPrev && !bus.iorN) || (s.iowPrev && !bus.iowN);
  assign iowRise = !s.iowPrev && bus.iowN;
  assign pciRise = bus.pinLevel[`IHP_PIN_G] && !s.pciPrev;

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  // next state of the register, epp wait, dma, irq and serial logic
  always_comb begin
    next_s = s;
    next_s.iorPrev = bus.iorN;
    next_s.iowPrev = bus.iowN;
    next_s.pciPrev = bus.pinLevel[`IHP_PIN_G];
    // read path, byte registered from the selected register
    next_s.rdOe = hit && !bus.iorN; // [RULE3]
    case (bus.addr[2:0])
      `IHP_OFS_CONFIG_REG_SIXTEEN: next_s.rdData = s.config_reg_sixteen;
      `IHP_OFS_CONFIG_REG_THIRTY_ONE: next_s.rdData = s.config_reg_thirty_one;
      `IHP_OFS_CONFIG_REG_3A: next_s.rdData = s.config_reg_3a;
      `IHP_OFS_CONFIG_REG_2C: next_s.rdData = s.config_reg_2c;
      `IHP_OFS_MODE: next_s.rdData = s.mode;
      `IHP_OFS_ROUTE: next_s.rdData = {5'h00, s.route};
      `IHP_OFS_GPIO: next_s.rdData = {2'h0, bus.pinLevel[`IHP_PIN_A],
        bus.pinLevel[`IHP_PIN_B], s.gpioDir, s.gpioOut};
      default: next_s.rdData = `IHP_RST_BYTE;
    endcase
    // write takes effect at the end of the write strobe
    if (hit && iowRise) begin // [RULE3]
      case (bus.addr[2:0])
        `IHP_OFS_CONFIG_REG_SIXTEEN: next_s.config_reg_sixteen = bus.dataBus;
        `IHP_OFS_CONFIG_REG_THIRTY_ONE: next_s.config_reg_thirty_one = bus.dataBus;
        `IHP_OFS_CONFIG_REG_3A: next_s.config_reg_3a = bus.dataBus;
        `IHP_OFS_CONFIG_REG_2C: next_s.config_reg_2c = bus.dataBus; // [RULE18]
        `IHP_OFS_MODE: next_s.mode = bus.dataBus;
        `IHP_OFS_ROUTE: next_s.route = bus.dataBus[2:0];
        `IHP_OFS_GPIO: begin
          next_s.gpioOut = bus.dataBus[1:0];
          next_s.gpioDir = bus.dataBus[3:2];
        end
        default: next_s.route = s.route;
      endcase
    end
    // epp cycle stretch: hold channel ready low for a fixed count
    if (s.waitCnt != 8'h00) next_s.waitCnt = s.waitCnt - 8'h01;
    if (hit && strobeFall && s.mode[`IHP_MODE_EPP]) next_s.waitCnt = EPP_WAIT; // [RULE7]
    // dma channels: request on start, end on ack plus terminal count
    for (int i = 0; i < 3; i++) begin
      next_s.dmaDone[i] = s.drq[i] && !bus.dackN[i] && bus.tc; // [RULE9]
      if (next_s.dmaDone[i]) next_s.drq[i] = 1'b0; // [RULE9]
      if (dmaStart[i]) next_s.drq[i] = 1'b1; // [RULE8]
    end
    // interrupt outputs with the routed external request
    for (int k = 0; k < 8; k++) begin
      next_s.irqOut[k] = irqSrc[k] || (routedIrqInput && (s.route == 3'(k))); // [RULE10]
    end
    next_s.irqPrev = s.irqOut;
    // serial irq: request a start slot on a new interrupt edge
    if (|(s.irqOut & ~s.irqPrev)) next_s.serPend = 1'b1;
    if (pciRise) begin // [RULE13]
      if (s.serLow) begin
        next_s.serLow = 1'b0;
      end else if (s.serPend && bus.pinLevel[`IHP_PIN_H]) begin
        next_s.serLow = 1'b1; // [RULE14]
        next_s.serPend = 1'b0;
      end
    end
    if (!serMode) begin
      next_s.serLow = 1'b0;
      next_s.serPend = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin // [RULE1]
      s <= '0;
      // strobes and pci clock idle high: no false edge after reset
      s.iorPrev <= 1'b1;
      s.iowPrev <= 1'b1;
      s.pciPrev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  //------------------------------------------------------------
  // pin functions
  //------------------------------------------------------------
  // pin muxing for gpio and serial irq alternates
  always_comb begin
    bus.pinOut = s.irqOut;
    bus.pinOe = 8'hff;
    if (s.config_reg_sixteen[`IHP_BIT_PINA_SEL]) begin // [RULE11]
      bus.pinOut[`IHP_PIN_A] = s.gpioOut[1];
      bus.pinOe[`IHP_PIN_A] = s.gpioDir[1];
    end
    if (s.config_reg_sixteen[`IHP_BIT_PINB_SEL]) begin // [RULE12]
      bus.pinOut[`IHP_PIN_B] = s.gpioOut[0];
      bus.pinOe[`IHP_PIN_B] = s.gpioDir[0];
    end
    if (serMode) begin
      bus.pinOe[`IHP_PIN_G] = 1'b0; // [RULE13]
      bus.pinOut[`IHP_PIN_H] = 1'b0; // [RULE14]
      bus.pinOe[`IHP_PIN_H] = s.serLow; // [RULE14]
    end
  end

  // bus outputs
  assign bus.devData = s.rdData;
  assign bus.devDataOe = s.rdOe; // [RULE3]
  assign bus.chrdyOe = (s.waitCnt != 8'h00); // [RULE7]
  assign bus.drq = s.drq; // [RULE8]

  //------------------------------------------------------------
  // power management pulses
  //------------------------------------------------------------
  assign sciFire = pmEvent && s.mode[`IHP_MODE_ACPI]; // [RULE15]
  assign smiFire = pmEvent && !s.mode[`IHP_MODE_ACPI] // [RULE16]
    && s.config_reg_3a[`IHP_BIT_MGMT_IRQ_ENABLE]; // [RULE17]

  ihp_pulse u_sci (
    .clk(clk),
    .reset(rst),
    .fire(sciFire),
    .active(sciActive)
  );

  ihp_pulse u_smi (
    .clk(clk),
    .reset(rst),
    .fire(smiFire),
    .active(smiActive)
  );

  assign bus.sciOe = sciActive; // [RULE15]
  assign bus.smiOe = smiActive && s.config_reg_3a[`IHP_BIT_MGMT_IRQ_ENABLE]; // [RULE17]

  // user-side status
  assign dmaDone = s.dmaDone;
  assign clockSelect = s.config_reg_2c[`IHP_BIT_CLKSEL];
  assign ecpMode = s.mode[`IHP_MODE_ECP];
  assign eppMode = s.mode[`IHP_MODE_EPP];
  assign acpiMode = s.mode[`IHP_MODE_ACPI];
endmodule // ihp_device
`default_nettype wire

// ==== ihp_host.sv ====
`include "ihp_consts.svh"
`default_nettype none
module ihp_host #(
  parameter logic [7:0] STROBE_CYC = 8'h03,
  parameter logic [7:0] PCI_DIV = 8'h04
) (
  input wire logic clk,
  input wire logic reset,
  ihp_isa_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  ihp_pkg::ihp_host_t s;
  ihp_pkg::ihp_host_t next_s;
  logic apbSetup;
  logic apbWrite;
  logic apbRead;
  logic [2:0] dack;
  logic [4:0] ev;

  //------------------------------------------------------------
  // dma acknowledge, lowest channel first
  //------------------------------------------------------------
  always_comb begin
    dack = 3'h0;
    if (s.ctrl[`IHP_CTRL_DACK]) begin
      if (bus.drq[0]) dack = 3'h1; // [RULE8]
      else if (bus.drq[1]) dack = 3'h2;
      else if (bus.drq[2]) dack = 3'h4;
    end
  end

  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && penable && !pwrite;

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  // apb registers, isa cycle sequencer, event capture
  always_comb begin
    next_s = s;
    next_s.tc = 1'b0;
    ev = 5'h00;
    if (apbSetup) begin
      case (paddr)
        `IHP_APB_STATUS: next_s.prdata = {12'h000, bus.drq, bus.pinLevel, s.rdata,
          (s.state != ihp_pkg::H_IDLE)};
        `IHP_APB_CTRL: next_s.prdata = {29'h0, s.ctrl};
        `IHP_APB_ISTAT: next_s.prdata = {27'h0, s.stat};
        `IHP_APB_IMASK: next_s.prdata = {27'h0, s.mask};
        default: next_s.prdata = 32'h0;
      endcase
    end
    if (apbWrite) begin
      case (paddr)
        `IHP_APB_CMD: begin
          // config bytes, clock select among them, go out as bus writes
          if (s.state == ihp_pkg::H_IDLE) begin // [RULE18]
            next_s.addr = pwdata[9:0]; // [RULE4]
            next_s.a10 = pwdata[`IHP_CMD_A10];
            next_s.wdata = pwdata[`IHP_CMD_DLSB +: 8];
            next_s.wr = pwdata[`IHP_CMD_WR];
            next_s.state = ihp_pkg::H_SETUP;
          end
        end
        `IHP_APB_CTRL: begin
          next_s.ctrl = pwdata[2:0]; // [RULE1]
          next_s.tc = pwdata[`IHP_CTRL_TC] && (dack != 3'h0); // [RULE9]
        end
        `IHP_APB_IMASK: next_s.mask = pwdata[4:0];
        default: next_s.mask = s.mask;
      endcase
    end
    // isa i/o cycle: setup, strobe held while channel ready is low
    case (s.state)
      ihp_pkg::H_IDLE: next_s.cnt = STROBE_CYC;
      ihp_pkg::H_SETUP: next_s.state = ihp_pkg::H_STROBE;
      ihp_pkg::H_STROBE: begin
        if (s.cnt != 8'h00) begin
          next_s.cnt = s.cnt - 8'h01;
        end else if (bus.chrdy) begin
          if (!s.wr) next_s.rdata = bus.dataBus;
          next_s.state = ihp_pkg::H_RECOVER;
        end
      end
      ihp_pkg::H_RECOVER: begin
        next_s.state = ihp_pkg::H_IDLE;
        ev[`IHP_EV_DONE] = 1'b1;
      end
      default: next_s.state = ihp_pkg::H_IDLE;
    endcase
    // pci clock divider for serial irq timing
    if (s.pciCnt >= PCI_DIV - 8'h01) begin
      next_s.pciCnt = 8'h00;
      next_s.pci_clock_in = !s.pci_clock_in;
    end else begin
      next_s.pciCnt = s.pciCnt + 8'h01;
    end
    // events and sticky status, set beats read-clear
    ev[`IHP_EV_DRQ] = |(bus.drq & ~s.drqPrev);
    ev[`IHP_EV_SCI] = s.sciPrev && !bus.sciLevel;
    ev[`IHP_EV_SMI] = s.smiPrev && !bus.smiLevel;
    ev[`IHP_EV_SER] = s.ctrl[`IHP_CTRL_SER] && s.serPrev && !bus.pinLevel[`IHP_PIN_H];
    next_s.drqPrev = bus.drq;
    next_s.sciPrev = bus.sciLevel;
    next_s.smiPrev = bus.smiLevel;
    next_s.serPrev = bus.pinLevel[`IHP_PIN_H];
    // istat answer takes setup-cycle events too, else the clear would lose them
    if (apbSetup && (paddr == `IHP_APB_ISTAT)) next_s.prdata = {27'h0, s.stat | ev};
    if (apbRead && (paddr == `IHP_APB_ISTAT)) next_s.stat = ev;
    else next_s.stat = s.stat | ev;
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) s <= '0;
    else s <= next_s;
  end

  //------------------------------------------------------------
  // pin drive
  //------------------------------------------------------------
  assign bus.masterReset = s.ctrl[`IHP_CTRL_MR]; // [RULE1]
  assign bus.csN = (s.state == ihp_pkg::H_IDLE); // [RULE2]
  assign bus.aen = (dack != 3'h0); // [RULE6]
  assign bus.addr = s.addr; // [RULE4]
  assign bus.addr10 = s.a10;
  assign bus.iorN = !((s.state == ihp_pkg::H_STROBE) && !s.wr);
  assign bus.iowN = !((s.state == ihp_pkg::H_STROBE) && s.wr);
  assign bus.hostData = s.wdata;
  assign bus.hostDataOe = (s.state != ihp_pkg::H_IDLE) && s.wr;
  assign bus.dackN = ~dack; // [RULE8]
  assign bus.tc = s.tc; // [RULE9]
  assign bus.hostPciClk = s.pci_clock_in;
  assign bus.hostPciOe = s.ctrl[`IHP_CTRL_SER];

  // apb answers, zero wait
  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(s.stat & s.mask);
endmodule // ihp_host
`default_nettype wire

// ==== ihp_isa_sva.sv ====
`default_nettype none
module ihp_isa_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic masterReset,
  input wire logic csN,
  input wire logic aen,
  input wire logic iorN,
  input wire logic iowN,
  input wire logic tc,
  input wire logic [2:0] dackN,
  input wire logic [2:0] drq,
  input wire logic devDataOe,
  input wire logic chrdyOe,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pinLevel,
  input wire logic sciOe,
  input wire logic smiOe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE = 50;
  logic [7:0] sciRun;
  logic [7:0] smiRun;
  // ----------------------------------
  // length of each sci and smi open-drain pulse
  // ----------------------------------
  always_ff @(posedge clk) begin
    sciRun <= sciOe ? sciRun + 8'h01 : 8'h00;
    smiRun <= smiOe ? smiRun + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_MR_CLEAR: assert property (masterReset |=>
    drq == 3'h0 && !sciOe && !smiOe && !chrdyOe)
    else $error("master reset left state");
  AST_CS_IDLE: assert property (csN && $past(csN) |-> !devDataOe)
    else $error("data driven without select");
  AST_AEN_IDLE: assert property (aen && $past(aen) |-> !devDataOe)
    else $error("data driven in dma cycle");
  AST_RD_OE: assert property (devDataOe |-> $past(!iorN && !csN && !aen))
    else $error("data driven outside read");
  AST_EPP_LEN: assert property ($rose(chrdyOe) |-> chrdyOe [*8] ##1 !chrdyOe)
    else $error("wait stretch length wrong");
  AST_EPP_HOLD: assert property ((!iorN || !iowN) && chrdyOe |=> (!iorN || !iowN))
    else $error("strobe ended while not ready");
  AST_DRQ_FALL: assert property (!$past(masterReset) |->
    ($past(drq) & ~drq & ~({3{$past(tc)}} & ~$past(dackN))) == 3'h0)
    else $error("request dropped without count");
  AST_SCI_LEN: assert property ($fell(sciOe) && !$past(masterReset) |->
    sciRun >= PULSE)
    else $error("short control pulse");
  AST_SMI_LEN: assert property ($fell(smiOe) && !$past(masterReset) |->
    smiRun >= PULSE)
    else $error("short management pulse");
  AST_SER_G: assert property (!pinOe[7] |-> !pinOe[6])
    else $error("pin g driven in serial mode");
  AST_SER_H: assert property (!pinOe[6] |-> !pinOut[7])
    else $error("serial line driven high");
  AST_SER_SYNC: assert property ($rose(pinOe[7]) && !pinOe[6] |->
    $past(pinLevel[6]) && !$past(pinLevel[6], 2))
    else $error("serial start off clock edge");
endmodule // ihp_isa_sva
`default_nettype wire

// ==== isa_host_pin_interface_tb.sv ====
`include "ihp_consts.svh"
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module isa_host_pin_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irq, clockSelect, ecpMode, eppMode, acpiMode;
  logic [7:0] irqSrc = 8'h00;
  logic routedIrqInput = 1'b0;
  logic [2:0] dmaStart = 3'h0;
  logic pmEvent = 1'b0;
  logic [2:0] dmaDone;
  logic [2:0] doneSeen = 3'h0;
  int n_fail = 0;
  int total_checks = 0;
  ihp_isa_if isaBus ();
  ihp_device u_ihp_device (.clk(clk), .reset(reset), .bus(isaBus.dev), .irqSrc(irqSrc),
    .routedIrqInput(routedIrqInput), .dmaStart(dmaStart), .pmEvent(pmEvent),
    .dmaDone(dmaDone), .clockSelect(clockSelect), .ecpMode(ecpMode), .eppMode(eppMode),
    .acpiMode(acpiMode));
  ihp_host u_ihp_host (.clk(clk), .reset(reset), .bus(isaBus.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  ihp_isa_sva u_ihp_isa_sva (.clk(clk), .reset(reset), .masterReset(isaBus.masterReset),
    .csN(isaBus.csN), .aen(isaBus.aen), .iorN(isaBus.iorN), .iowN(isaBus.iowN),
    .tc(isaBus.tc), .dackN(isaBus.dackN), .drq(isaBus.drq), .devDataOe(isaBus.devDataOe),
    .chrdyOe(isaBus.chrdyOe), .pinOut(isaBus.pinOut), .pinOe(isaBus.pinOe),
    .pinLevel(isaBus.pinLevel), .sciOe(isaBus.sciOe), .smiOe(isaBus.smiOe));
  always #2 clk = ~clk;
  // sticky record of completed dma channels
  always @(posedge clk) begin
    if (!reset) doneSeen <= doneSeen | dmaDone;
  end
  // ----------------------------------
  // bus cycle tasks
  // ----------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic isa(input logic wr, input logic a10, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, `IHP_APB_CMD, {12'h000, wr, d, a10, a});
    do begin
      apb(1'b0, `IHP_APB_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    `CHK("cycle end", 1'b0, rd[0])
  endtask
  task automatic dw(input logic [2:0] i, input logic [7:0] d);
    isa(1'b1, 1'b0, {7'h60, i}, d);
  endtask
  task automatic dr(input logic [2:0] i, input logic [7:0] e);
    isa(1'b0, 1'b0, {7'h60, i}, 8'h00);
    `CHK("device reg", e, rd[8:1])
  endtask
  // ----------------------------------
  // scenarios
  // ----------------------------------
  task automatic t_regs();
    for (int i = 0; i < 7; i++) dr(3'(i), 8'h00);
    dw(3'h3, 8'ha5);
    dr(3'h3, 8'ha5);
    `CHK("clock select", 1'b1, clockSelect)
    isa(1'b1, 1'b0, 10'h307, 8'h5a);
    isa(1'b0, 1'b0, 10'h307, 8'h00);
    `CHK("past last reg", 8'hff, rd[8:1])
    isa(1'b0, 1'b0, 10'h2c3, 8'h00);
    `CHK("other base", 8'hff, rd[8:1])
    dw(3'h4, 8'h01);
    `CHK("ecp mode", 1'b1, ecpMode)
    isa(1'b0, 1'b1, 10'h303, 8'h00);
    `CHK("a10 set", 8'hff, rd[8:1])
    dr(3'h3, 8'ha5);
    dw(3'h4, 8'h02);
    dr(3'h3, 8'ha5);
    `CHK("epp mode", 1'b1, eppMode)
    dw(3'h4, 8'h00);
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("slave error", 1'b0, pslverr)
  endtask
  task automatic t_mr();
    apb(1'b1, `IHP_APB_CTRL, 32'h1);
    apb(1'b0, `IHP_APB_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    apb(1'b1, `IHP_APB_CTRL, 32'h0);
    dr(3'h3, 8'h00);
    `CHK("clock select", 1'b0, clockSelect)
  endtask
  task automatic t_irq();
    irqSrc <= 8'h81;
    routedIrqInput <= 1'b1;
    dw(3'h5, 8'h02);
    apb(1'b0, `IHP_APB_STATUS, 32'h0);
    `CHK("irq pins", 8'h85, rd[16:9])
    dw(3'h0, 8'h30);
    dw(3'h6, 8'h05);
    apb(1'b0, `IHP_APB_STATUS, 32'h0);
    `CHK("gpio pins", 8'h86, rd[16:9])
    dr(3'h6, 8'h15);
    isaBus.pinExt <= 2'b01;
    dr(3'h6, 8'h35);
    dw(3'h0, 8'h00);
    irqSrc <= 8'h00;
    routedIrqInput <= 1'b0;
  endtask
  task automatic t_dma();
    apb(1'b0, `IHP_APB_ISTAT, 32'h0);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `IHP_APB_IMASK, (k == 2) ? 32'h0 : 32'h2);
      dmaStart <= 3'(1 << k);
      @(posedge clk);
      dmaStart <= 3'h0;
      tick(3);
      `CHK("irq line", (k != 2), irq)
      apb(1'b0, `IHP_APB_STATUS, 32'h0);
      `CHK("drq", 3'(1 << k), rd[19:17])
      apb(1'b1, `IHP_APB_CTRL, 32'h2);
      tick(2);
      `CHK("ack", ~3'(1 << k), isaBus.dackN)
      `CHK("aen", 1'b1, isaBus.aen)
      apb(1'b1, `IHP_APB_CTRL, 32'ha);
      tick(2);
      `CHK("done", 1'b1, doneSeen[k])
      `CHK("drq end", 1'b0, isaBus.drq[k])
      apb(1'b0, `IHP_APB_ISTAT, 32'h0);
      `CHK("drq event", 5'h02, rd[4:0] & 5'h02)
      `CHK("irq clear", 1'b0, irq)
      apb(1'b1, `IHP_APB_CTRL, 32'h0);
    end
  endtask
  task automatic t_pm(input logic [7:0] mode, input logic [7:0] en, input logic [4:0] e);
    dw(3'h4, mode);
    `CHK("acpi mode", mode[2], acpiMode)
    dw(3'h2, en);
    apb(1'b0, `IHP_APB_ISTAT, 32'h0);
    pmEvent <= 1'b1;
    @(posedge clk);
    pmEvent <= 1'b0;
    tick(60);
    apb(1'b0, `IHP_APB_ISTAT, 32'h0);
    `CHK("pm event", e, rd[4:0] & 5'h0c)
  endtask
  task automatic t_ser();
    dw(3'h1, 8'h10);
    apb(1'b1, `IHP_APB_CTRL, 32'h4);
    apb(1'b0, `IHP_APB_ISTAT, 32'h0);
    `CHK("pin g input", 1'b0, isaBus.pinOe[6])
    irqSrc <= 8'h01;
    tick(40);
    apb(1'b0, `IHP_APB_ISTAT, 32'h0);
    `CHK("serial start", 5'h10, rd[4:0] & 5'h10)
    irqSrc <= 8'h00;
    apb(1'b1, `IHP_APB_CTRL, 32'h0);
    dw(3'h1, 8'h00);
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    isaBus.pinExt <= 2'b00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_mr();
    t_irq();
    t_dma();
    t_pm(8'h04, 8'h00, 5'h04);
    t_pm(8'h00, 8'h00, 5'h00);
    t_pm(8'h00, 8'h01, 5'h08);
    t_ser();
    end_of_test();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
endmodule // isa_host_pin_interface_tb
`default_nettype wire
